//--- rtl/dma_channel_params.svh
// Constants of the paired full address channel: offsets, fields, resets.
// Assumes a word-indexed register port with a 4-bit address.
//
// How it works
// - Normal mode: count A counts transfers down, ends at zero.
// - Normal mode: count B is ignored for counting.
// - Block mode: upper byte of count A counts the block, reloads from lower.
// - Block mode: count B counts finished blocks, ends at zero.
// - Reset and standby leave both count registers untouched.
// - Full address mode when control A bits 2 and 1 are both one.
// - Full address mode ignores the peripheral address register.
// - Reset and standby clear both control registers.
// - Channel runs with both enables set; auto-request starts at once.
// - Channel enable clears itself at the end; no requests while clear.
// - End interrupt raised on enable clear when control A bit 3 set.
// - Control A bit 6 picks byte or word units.
// - Control A bits 5 and 4 step the source address.
// - Control B bits 5 and 4 step the destination address.
// - Control A bit 0 picks normal or block transfer mode.
// - Interrupt event clears master enable; setting it again resumes.
// - Control B bit 6 stores and returns written values.
// - Control B bit 3 picks which side is the block area.
// - Normal activation codes: burst, cycle-steal, falling edge, low level.
// - Cycle-steal releases the bus after each unit; burst keeps it.
`ifndef DMA_CHANNEL_PARAMS_SVH
`define DMA_CHANNEL_PARAMS_SVH

`define OFS_SOURCE      4'h0
`define OFS_DEST        4'h1
`define OFS_PERIPH      4'h2
`define OFS_COUNT_A     4'h3
`define OFS_COUNT_B     4'h4
`define OFS_CONTROL_A   4'h5
`define OFS_CONTROL_B   4'h6
`define OFS_STATUS      4'h7

`define CONTROL_RESET   8'h00
`define ADDR_UPPER_READ 8'hff

`define BIT_ENABLE      7
`define BIT_UNIT        6
`define BIT_DIR         5
`define BIT_STEP        4
`define BIT_INT_EN      3
`define BIT_AREA        3
`define BIT_MODE_HI     2
`define BIT_MODE_LO     1
`define BIT_BLOCK       0

`define ACT_BURST       3'h0
`define ACT_STEAL       3'h2
`define ACT_EDGE        3'h6
`define ACT_LEVEL       3'h7

`endif

//--- rtl/dma_channel_pkg.sv
// Types shared by the channel controller.
// Assumes the constants header is compiled alongside.
package dma_channel_pkg;

	typedef enum logic [3:0] {
		st_idle    = 4'b0001,
		st_wait    = 4'b0010,
		st_move    = 4'b0100,
		st_release = 4'b1000
	} state_type;

endpackage : dma_channel_pkg

//--- rtl/dma_full_address_channel_ctrl.sv
// Control and counting logic of one paired channel in full address mode.
// Assumes a bus agent that moves one unit per cycle of xfer_req and answers
// with a one-cycle xfer_ack; nmi_event and itu_trigger are same-clock pulses.
`timescale 1ns/1ps
`include "dma_channel_params.svh"

module dma_full_address_channel_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        nmi_event,
	input  wire logic        standby,
	input  wire logic        external_request_input,
	input  wire logic [3:0]  itu_trigger,
	input  wire logic        xfer_ack,
	output logic             xfer_req,
	output logic             xfer_word,
	output logic      [23:0] src_addr,
	output logic      [23:0] dst_addr,
	output logic             transfer_end_interrupt,
	output logic             channel_active
);

	// ==========================================================
	// State
	// ==========================================================
	dma_channel_pkg::state_type state_reg, state_next;
	logic [23:0] src_reg, src_next;
	logic [23:0] dst_reg, dst_next;
	logic [23:0] periph_reg, periph_next;
	logic [23:0] base_reg, base_next;
	logic [15:0] cnt_a_reg, cnt_a_next;
	logic [15:0] cnt_b_reg, cnt_b_next;
	logic [7:0]  ctl_a_reg, ctl_a_next;
	logic [7:0]  ctl_b_reg, ctl_b_next;
	logic        arm_a_reg, arm_a_next;
	logic        arm_b_reg, arm_b_next;
	logic        end_reg, end_next;
	logic        pend_reg, pend_next;
	logic        inblk_reg, inblk_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        sync1_reg, sync2_reg, prev_reg;

	// ==========================================================
	// Decode
	// ==========================================================
	logic        full_mode;
	logic        block_mode;
	logic        enabled;
	logic [2:0]  act;
	logic        fall;
	logic        ev;
	logic        auto_req;
	logic        steal;
	logic        go;
	logic [23:0] step;
	logic [15:0] cnt_a_dec;
	logic [15:0] cnt_b_dec;
	logic [7:0]  blk_dec;
	logic [23:0] src_step;
	logic [23:0] dst_step;

	assign full_mode = ctl_a_reg[`BIT_MODE_HI] & ctl_a_reg[`BIT_MODE_LO];
	assign block_mode = ctl_a_reg[`BIT_BLOCK];
	assign enabled = full_mode & ctl_a_reg[`BIT_ENABLE]
		& ctl_b_reg[`BIT_ENABLE];
	assign act = ctl_b_reg[2:0];
	// The request pin is read only after two flip-flops.
	assign fall = prev_reg & ~sync2_reg;
	assign step = ctl_a_reg[`BIT_UNIT] ? 24'h000002 : 24'h000001;
	assign cnt_a_dec = cnt_a_reg - 16'h0001;
	assign cnt_b_dec = cnt_b_reg - 16'h0001;
	assign blk_dec = cnt_a_reg[15:8] - 8'h01;

	// Unusable codes start nothing, so a bad setup just leaves the
	// channel waiting instead of moving data unasked.
	always_comb
	begin
		auto_req = 1'b0;
		steal = 1'b0;
		ev = 1'b0;
		if (!block_mode)
		begin
			case (act)
				`ACT_BURST: auto_req = 1'b1;
				`ACT_STEAL:
				begin
					auto_req = 1'b1;
					steal = 1'b1;
				end
				`ACT_EDGE:  ev = fall;
				default:    ev = 1'b0;
			endcase
		end
		else if (!act[2])
			ev = itu_trigger[act[1:0]];
		else if (act == `ACT_EDGE)
			ev = fall;
	end

	assign go = auto_req | inblk_reg | pend_reg
		| (!block_mode && act == `ACT_LEVEL && !sync2_reg);

	always_comb
	begin
		src_step = src_reg;
		dst_step = dst_reg;
		if (ctl_a_reg[`BIT_STEP])
			src_step = ctl_a_reg[`BIT_DIR] ? src_reg - step : src_reg + step;
		if (ctl_b_reg[`BIT_STEP])
			dst_step = ctl_b_reg[`BIT_DIR] ? dst_reg - step : dst_reg + step;
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		state_next = state_reg;
		src_next = src_reg;
		dst_next = dst_reg;
		periph_next = periph_reg;
		base_next = base_reg;
		cnt_a_next = cnt_a_reg;
		cnt_b_next = cnt_b_reg;
		ctl_a_next = ctl_a_reg;
		ctl_b_next = ctl_b_reg;
		arm_a_next = arm_a_reg;
		arm_b_next = arm_b_reg;
		end_next = end_reg;
		pend_next = pend_reg;
		inblk_next = inblk_reg;
		rdata_next = 32'h00000000;

		// Register writes come first so the engine below overrides them.
		if (reg_write)
		begin
			case (reg_addr)
				`OFS_SOURCE:  src_next = reg_wdata[23:0];
				`OFS_DEST:    dst_next = reg_wdata[23:0];
				`OFS_PERIPH:  periph_next = reg_wdata[23:0];
				`OFS_COUNT_A: cnt_a_next = reg_wdata[15:0];
				`OFS_COUNT_B: cnt_b_next = reg_wdata[15:0];
				`OFS_CONTROL_A:
				begin
					ctl_a_next = reg_wdata[7:0];
					ctl_a_next[`BIT_ENABLE] = reg_wdata[`BIT_ENABLE]
						& (ctl_a_reg[`BIT_ENABLE] | arm_a_reg);
					arm_a_next = 1'b0;
					end_next = 1'b0;
				end
				`OFS_CONTROL_B:
				begin
					ctl_b_next = reg_wdata[7:0];
					ctl_b_next[`BIT_ENABLE] = reg_wdata[`BIT_ENABLE]
						& (ctl_b_reg[`BIT_ENABLE] | arm_b_reg);
					arm_b_next = 1'b0;
				end
				default: ;
			endcase
		end

		if (reg_read)
		begin
			case (reg_addr)
				`OFS_SOURCE:  rdata_next = {`ADDR_UPPER_READ, src_reg};
				`OFS_DEST:    rdata_next = {`ADDR_UPPER_READ, dst_reg};
				`OFS_PERIPH:  rdata_next = {8'h00, periph_reg};
				`OFS_COUNT_A: rdata_next = {16'h0000, cnt_a_reg};
				`OFS_COUNT_B: rdata_next = {16'h0000, cnt_b_reg};
				`OFS_CONTROL_A:
				begin
					rdata_next = {24'h000000, ctl_a_reg};
					if (!ctl_a_reg[`BIT_ENABLE])
						arm_a_next = 1'b1;
				end
				`OFS_CONTROL_B:
				begin
					rdata_next = {24'h000000, ctl_b_reg};
					if (!ctl_b_reg[`BIT_ENABLE])
						arm_b_next = 1'b1;
				end
				`OFS_STATUS:
					rdata_next = {24'h000000, state_reg, inblk_reg,
						pend_reg, enabled, end_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end

		// A request seen while the enable is clear is dropped.
		if (ev && ctl_a_reg[`BIT_ENABLE])
			pend_next = 1'b1;
		else if (!ctl_a_reg[`BIT_ENABLE])
			pend_next = 1'b0;

		case (state_reg)
			dma_channel_pkg::st_idle:
			begin
				inblk_next = 1'b0;
				if (enabled)
					state_next = dma_channel_pkg::st_wait;
			end
			dma_channel_pkg::st_wait:
			begin
				if (!enabled)
					state_next = dma_channel_pkg::st_wait;
				else if (go)
				begin
					state_next = dma_channel_pkg::st_move;
					if (!inblk_reg)
					begin
						pend_next = ev;
						inblk_next = block_mode;
						base_next = ctl_b_reg[`BIT_AREA] ? src_reg : dst_reg;
					end
				end
				if (!ctl_a_reg[`BIT_ENABLE])
					state_next = dma_channel_pkg::st_idle;
			end
			dma_channel_pkg::st_move:
			begin
				// A unit in flight always finishes before a suspension.
				if (xfer_ack)
				begin
					src_next = src_step;
					dst_next = dst_step;
					state_next = dma_channel_pkg::st_wait;
					if (!block_mode)
					begin
						cnt_a_next = cnt_a_dec;
						if (cnt_a_dec == 16'h0000)
						begin
							ctl_a_next[`BIT_ENABLE] = 1'b0;
							end_next = 1'b1;
							state_next = dma_channel_pkg::st_idle;
						end
						else if (steal)
							state_next = dma_channel_pkg::st_release;
						else if (auto_req && enabled)
							state_next = dma_channel_pkg::st_move;
					end
					else if (blk_dec == 8'h00)
					begin
						cnt_a_next = {cnt_a_reg[7:0], cnt_a_reg[7:0]};
						cnt_b_next = cnt_b_dec;
						inblk_next = 1'b0;
						if (ctl_b_reg[`BIT_AREA])
							src_next = base_reg;
						else
							dst_next = base_reg;
						if (cnt_b_dec == 16'h0000)
						begin
							ctl_a_next[`BIT_ENABLE] = 1'b0;
							end_next = 1'b1;
							state_next = dma_channel_pkg::st_idle;
						end
					end
					else
					begin
						cnt_a_next = {blk_dec, cnt_a_reg[7:0]};
						if (enabled)
							state_next = dma_channel_pkg::st_move;
					end
				end
			end
			dma_channel_pkg::st_release:
				state_next = dma_channel_pkg::st_wait;
			default: state_next = dma_channel_pkg::st_idle;
		endcase

		// The interrupt event beats a software write of the master enable.
		if (nmi_event)
			ctl_b_next[`BIT_ENABLE] = 1'b0;

		// Standby leaves the count registers as they are.
		if (standby)
		begin
			ctl_a_next = `CONTROL_RESET;
			ctl_b_next = `CONTROL_RESET;
			arm_a_next = 1'b0;
			arm_b_next = 1'b0;
			pend_next = 1'b0;
			inblk_next = 1'b0;
			state_next = dma_channel_pkg::st_idle;
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	// Counts and addresses have no reset: they keep their value.
	always_ff @(posedge ref_clk)
	begin
		src_reg <= src_next;
		dst_reg <= dst_next;
		periph_reg <= periph_next;
		base_reg <= base_next;
		cnt_a_reg <= cnt_a_next;
		cnt_b_reg <= cnt_b_next;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= dma_channel_pkg::st_idle;
			ctl_a_reg <= `CONTROL_RESET;
			ctl_b_reg <= `CONTROL_RESET;
			arm_a_reg <= 1'b0;
			arm_b_reg <= 1'b0;
			end_reg <= 1'b0;
			pend_reg <= 1'b0;
			inblk_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			ctl_a_reg <= ctl_a_next;
			ctl_b_reg <= ctl_b_next;
			arm_a_reg <= arm_a_next;
			arm_b_reg <= arm_b_next;
			end_reg <= end_next;
			pend_reg <= pend_next;
			inblk_reg <= inblk_next;
			rdata_reg <= rdata_next;
			sync1_reg <= external_request_input;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign reg_rdata = rdata_reg;
	assign xfer_req = (state_reg == dma_channel_pkg::st_move);
	assign xfer_word = ctl_a_reg[`BIT_UNIT];
	assign src_addr = src_reg;
	assign dst_addr = dst_reg;
	assign transfer_end_interrupt = end_reg & ctl_a_reg[`BIT_INT_EN];
	assign channel_active = enabled;

endmodule : dma_full_address_channel_ctrl

//--- test/dma_channel_props.sv
// Checker for the paired channel controller, bound from the bench.
// Assumes it sees only the controller's ports, all on one clock.
`timescale 1ns/1ps
module dma_channel_props (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic        nmi_event,
	input wire logic        standby,
	input wire logic        xfer_ack,
	input wire logic        xfer_req,
	input wire logic [23:0] src_addr,
	input wire logic [23:0] dst_addr,
	input wire logic        transfer_end_interrupt,
	input wire logic        channel_active
);
	// ==========
	// Properties
	logic acked;
	assign acked = xfer_req && xfer_ack;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_rdata_slot;
		reg_rdata != 32'h0 |-> $past(reg_read);
	endproperty
	a_rdata_slot: assert property (p_rdata_slot)
		else $error("read data outside its slot");
	property p_standby;
		standby |=> !channel_active && !transfer_end_interrupt;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby left the channel enabled");
	property p_nmi;
		nmi_event |=> !channel_active;
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("nmi did not suspend the channel");
	property p_end_irq;
		$rose(transfer_end_interrupt) |-> $fell(channel_active);
	endproperty
	a_end_irq: assert property (p_end_irq)
		else $error("end interrupt without enable clear");
	property p_start;
		$rose(xfer_req) |-> channel_active;
	endproperty
	a_start: assert property (p_start)
		else $error("request raised while disabled");
	property p_req_hold;
		xfer_req && !xfer_ack && !standby |=> xfer_req;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request dropped before acknowledge");
	property p_src_still;
		!acked && !reg_write |=> $stable(src_addr);
	endproperty
	a_src_still: assert property (p_src_still)
		else $error("source moved without a transfer");
	property p_dst_still;
		!acked && !reg_write |=> $stable(dst_addr);
	endproperty
	a_dst_still: assert property (p_dst_still)
		else $error("destination moved without a transfer");
	property p_auto_clear;
		$fell(channel_active) && !$past(nmi_event) && !$past(standby)
			&& !$past(reg_write) |-> $past(acked);
	endproperty
	a_auto_clear: assert property (p_auto_clear)
		else $error("enable cleared without a finished unit");
endmodule : dma_channel_props

//--- test/dma_bus_agent.sv
// Bus agent model: moves one unit per request after a settable wait.
// Assumes the request holds until the acknowledge is seen.
`timescale 1ns/1ps
module dma_bus_agent (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       xfer_req,
	input  wire logic [3:0] lat,
	output logic            xfer_ack
);
	// ==========
	// Acknowledge
	logic [3:0] wait_reg;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			xfer_ack <= 1'b0;
			wait_reg <= 4'h0;
		end
		else if (xfer_ack || !xfer_req)
		begin
			xfer_ack <= 1'b0;
			wait_reg <= 4'h0;
		end
		else if (wait_reg >= lat)
			xfer_ack <= 1'b1;
		else
			wait_reg <= wait_reg + 4'h1;
	end
endmodule : dma_bus_agent

//--- test/dma_full_address_channel_ctrl_tb_top.sv
// Bench for the paired channel controller with a bus agent model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "dma_channel_params.svh"
module dma_full_address_channel_ctrl_tb_top;
	logic ref_clk, resetn, reg_write, reg_read, nmi_event, standby;
	logic external_request_input, xfer_ack, xfer_req, xfer_word;
	logic transfer_end_interrupt, channel_active;
	logic [3:0]  reg_addr, itu_trigger, lat;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [23:0] src_addr, dst_addr;
	int failures, n_tests, n_acks, n_gap, cyc;
	dma_full_address_channel_ctrl uut (.ref_clk, .resetn, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .nmi_event,
		.standby, .external_request_input, .itu_trigger, .xfer_ack,
		.xfer_req, .xfer_word, .src_addr, .dst_addr,
		.transfer_end_interrupt, .channel_active);
	dma_bus_agent agent (.ref_clk, .resetn, .xfer_req, .lat, .xfer_ack);
	// ==========
	// Tasks
	task chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd
	task results;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// Kick 1 pulses a timer trigger, 2 pulses the request pin, 3 holds it
	// low, 4 sends an interrupt event mid-run and then resumes.
	task run(input logic [7:0] ca, cb, input logic [15:0] na, nb,
		input int kick, input logic [3:0] sl, input logic [23:0] es, ed,
		input logic [15:0] ea, eb, input int ek, input logic ei);
		lat <= sl;
		n_acks = 0;
		n_gap = 0;
		wr(`OFS_SOURCE, 32'h100);
		wr(`OFS_DEST, 32'h200);
		wr(`OFS_COUNT_A, {16'h0, na});
		wr(`OFS_COUNT_B, {16'h0, nb});
		rd(`OFS_CONTROL_B, v);
		wr(`OFS_CONTROL_B, {24'h0, cb});
		rd(`OFS_CONTROL_A, v);
		wr(`OFS_CONTROL_A, {24'h0, ca});
		for (int i = 0; i < 300; i++)
		begin
			@(posedge ref_clk);
			itu_trigger <= (kick == 1 && i % 10 == 5) ? 4'h1 : 4'h0;
			external_request_input <= !(kick == 3
				|| (kick == 2 && i % 10 == 5));
			nmi_event <= (kick == 4 && i == 12);
			#1;
			if (channel_active !== 1'b1 && !(kick == 4 && i == 13))
				break;
			if (kick == 4 && i == 13)
			begin
				chk("suspend", {31'h0, channel_active}, 32'h0);
				rd(`OFS_CONTROL_B, v);
				chk("master", v, {24'h0, cb & 8'h7f});
				wr(`OFS_CONTROL_B, {24'h0, cb});
			end
		end
		external_request_input <= 1'b1;
		chk("units", n_acks, ek);
		// Start-up costs two idle cycles; cycle-steal adds two between units.
		if (kick == 0)
			chk("gaps", n_gap, cb[2:0] == `ACT_STEAL ? 2 * na : 2);
		rd(`OFS_SOURCE, v);
		chk("source", v, {8'hff, es});
		rd(`OFS_DEST, v);
		chk("dest", v, {8'hff, ed});
		rd(`OFS_COUNT_A, v);
		chk("count_a", v, {16'h0, ea});
		rd(`OFS_COUNT_B, v);
		chk("count_b", v, {16'h0, eb});
		chk("irq", {31'h0, transfer_end_interrupt}, {31'h0, ei});
		rd(`OFS_CONTROL_A, v);
		chk("ctrl_a", v, {24'h0, ek == 0 ? ca : ca & 8'h7f});
		chk("word", {31'h0, xfer_word}, {31'h0, ca[6]});
		chk("src_pin", {8'h0, src_addr}, {8'h0, es});
		chk("dst_pin", {8'h0, dst_addr}, {8'h0, ed});
		wr(`OFS_CONTROL_A, 32'h0);
		@(negedge ref_clk);
		chk("irq_clr", {31'h0, transfer_end_interrupt}, 32'h0);
		$display("test %h %h done", ca, cb);
	endtask : run
	// ==========
	// Sequence
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (xfer_req && xfer_ack)
			n_acks <= n_acks + 1;
		if (channel_active && !xfer_req)
			n_gap <= n_gap + 1;
		if (cyc == 20000)
		begin
			failures++;
			results;
		end
	end
	initial
	begin
		{resetn, reg_write, reg_read, nmi_event, standby} = 5'h0;
		{reg_addr, itu_trigger, lat, reg_wdata} = 44'h0;
		external_request_input = 1'b1;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(`OFS_CONTROL_A, v);
		chk("reset_a", v, 32'h0);
		rd(`OFS_CONTROL_B, v);
		chk("reset_b", v, 32'h0);
		rd(4'h8, v);
		chk("unmapped", v, 32'h0);
		rd(`OFS_STATUS, v);
		chk("status", v, 32'h10);
		wr(`OFS_PERIPH, 32'h00abcdef);
		rd(`OFS_PERIPH, v);
		chk("periph", v, 32'h00abcdef);
		wr(`OFS_CONTROL_B, 32'h40);
		rd(`OFS_CONTROL_B, v);
		chk("reserved", v, 32'h40);
		wr(`OFS_CONTROL_A, 32'h06);
		wr(`OFS_CONTROL_A, 32'h86);
		rd(`OFS_CONTROL_A, v);
		chk("no_arm", v, 32'h06);
		$display("test registers done");
		run(8'hde, 8'hb0, 16'h3, 16'h1234, 0, 4'h0, 24'h106, 24'h1fa,
			16'h0, 16'h1234, 3, 1'b1);
		run(8'h86, 8'h92, 16'h2, 16'h5, 0, 4'h3, 24'h100, 24'h202,
			16'h0, 16'h5, 2, 1'b0);
		run(8'h97, 8'h90, 16'h0202, 16'h2, 1, 4'h1, 24'h104, 24'h200,
			16'h0202, 16'h0, 4, 1'b0);
		run(8'h97, 8'h98, 16'h0202, 16'h2, 1, 4'h0, 24'h100, 24'h204,
			16'h0202, 16'h0, 4, 1'b0);
		run(8'h86, 8'h86, 16'h2, 16'h0, 2, 4'h0, 24'h100, 24'h200,
			16'h0, 16'h0, 2, 1'b0);
		run(8'h86, 8'h87, 16'h2, 16'h0, 3, 4'h2, 24'h100, 24'h200,
			16'h0, 16'h0, 2, 1'b0);
		run(8'h86, 8'h80, 16'h4, 16'h0, 4, 4'h4, 24'h100, 24'h200,
			16'h0, 16'h0, 4, 1'b0);
		run(8'h86, 8'h81, 16'h2, 16'h0, 3, 4'h0, 24'h100, 24'h200,
			16'h2, 16'h0, 0, 1'b0);
		wr(`OFS_CONTROL_A, 32'h4e);
		@(posedge ref_clk);
		standby <= 1'b1;
		@(posedge ref_clk);
		standby <= 1'b0;
		rd(`OFS_CONTROL_A, v);
		chk("stby_a", v, 32'h0);
		rd(`OFS_CONTROL_B, v);
		chk("stby_b", v, 32'h0);
		rd(`OFS_COUNT_A, v);
		chk("stby_cnt", v, 32'h2);
		$display("test standby done");
		results;
	end
endmodule : dma_full_address_channel_ctrl_tb_top
bind dma_full_address_channel_ctrl dma_channel_props chk_i (.ref_clk,
	.resetn, .reg_write, .reg_read, .reg_rdata, .nmi_event, .standby,
	.xfer_ack, .xfer_req, .src_addr, .dst_addr, .transfer_end_interrupt,
	.channel_active);
